// ===== high_speed_counter_core.sv
`timescale 1ns/10ps
// How it works
// - Channel runs linear or ring; linear is the default.
// - Reverse direction swaps up and down; normal is default.
// - Source: external inputs or internal 0.25, 1, 10, 100 us clocks.
// - Methods: quadrature x1/x2/x4, up/down x1/x2, dir+pulse x1/x2.
// - Z clears count on rise, fall, high or low level.
// - Z loads preset on rise, fall, high or low level.
// - Control 0 gates by level, optionally with clear or preset edge.
// - Control 1 unused or gates at positive or negative level.
// - Reset loads count with the configured default value.
// - A and B share a bypassable filter, 0.1 to 10 us.
// - Z has its own filter with the same choices.
// - Control inputs have a bypassable filter, default 2 ms.
// - A control used for gating cannot trigger capture.
// - Each match flag may clear the count on rise or fall.
module high_speed_counter_core
  import hsc_pkg::*;
#(
  parameter int US_CYCLES = NS_PER_US / CLK_PERIOD_NS
) (
  input wire logic sys_clk,
  input wire logic rst,
  // Pins
  input wire logic a_in,
  input wire logic b_in,
  input wire logic z_in,
  input wire logic ctl0_in,
  input wire logic ctl1_in,
  // Configuration
  input wire logic ring_mode,
  input wire logic ovf_en,
  input wire logic reverse_dir,
  input wire logic [2:0] src_sel,
  input wire logic [2:0] method_sel,
  input wire logic [3:0] z_func,
  input wire logic [2:0] ctl0_func,
  input wire logic [1:0] ctl1_func,
  input wire logic [2:0] ab_flt_sel,
  input wire logic [2:0] z_flt_sel,
  input wire logic [3:0] ctl_flt_sel,
  input wire logic signed [hsc_pkg::CNT_W-1:0] upper_lim,
  input wire logic signed [hsc_pkg::CNT_W-1:0] lower_lim,
  input wire logic signed [hsc_pkg::CNT_W-1:0] default_val,
  input wire logic signed [hsc_pkg::CNT_W-1:0] preset_val,
  input wire logic [2:0] cap0_sel,
  input wire logic [2:0] cap1_sel,
  // Comparison match clear
  input wire logic [hsc_pkg::CMP_N-1:0] cmp_match,
  input wire logic [hsc_pkg::CMP_N-1:0] cmp_rst_rise,
  input wire logic [hsc_pkg::CMP_N-1:0] cmp_rst_fall,
  input wire logic flag_clr,
  // Status
  output logic signed [hsc_pkg::CNT_W-1:0] count_r,
  output logic ovf_r,
  output logic unf_r,
  output logic cap0_trig_r,
  output logic cap1_trig_r,
  output logic cap_conflict
);
  import hsc_pkg::*;

  function automatic logic [FLT_W-1:0] abz_lim(input logic [2:0] sel);
    int ns;
    case (sel)
      3'h1: ns = ABZ_T1_NS;
      3'h2: ns = ABZ_T2_NS;
      3'h3: ns = ABZ_T3_NS;
      3'h4: ns = ABZ_T4_NS;
      3'h5: ns = ABZ_T5_NS;
      3'h6: ns = ABZ_T6_NS;
      default: ns = 0;
    endcase
    return (ns == 0) ? '0 : FLT_W'(ns / CLK_PERIOD_NS - 1);
  endfunction

  function automatic logic [FLT_W-1:0] ctl_lim(input logic [3:0] sel);
    int us;
    case (sel)
      4'h1: us = CTL_T1_US;
      4'h2: us = CTL_T2_US;
      4'h3: us = CTL_T3_US;
      4'h4: us = CTL_T4_US;
      4'h5: us = CTL_T5_US;
      4'h6: us = CTL_T6_US;
      4'h7: us = CTL_T7_US;
      4'h8: us = CTL_T8_US;
      4'h9: us = CTL_T9_US;
      4'ha: us = CTL_T10_US;
      4'hb: us = CTL_T11_US;
      default: us = 0;
    endcase
    return (us == 0) ? '0 : FLT_W'(us * US_CYCLES - 1);
  endfunction

  logic [4:0] sy1_r, sy2_r, flt_r, fltd_r;
  logic [FLT_W-1:0] fcnt_r [5];
  logic [FLT_W-1:0] flim [5];
  logic [TICK_W-1:0] tick_r, tick_lim;
  logic tick;
  logic a, b, z, c0, c1, arise, aedge, brise, bedge;
  logic zrise, zfall, c0rise, c0fall, c1rise, c1fall;
  logic raw_up, raw_dn, step_up, step_dn, gate, do_clr, do_pre, cmp_clr;
  logic at_upper, at_lower, ovf_ev, unf_ev;
  logic [CMP_N-1:0] cmpd_r;
  logic signed [CNT_W-1:0] count_nxt;

  // Two-stage synchronisers keep sampling in reset, so filters start at pin level
  always_ff @(posedge sys_clk) begin
    sy1_r <= {ctl1_in, ctl0_in, z_in, b_in, a_in};
    sy2_r <= sy1_r;
  end

  assign flim[0] = abz_lim(ab_flt_sel);
  assign flim[1] = abz_lim(ab_flt_sel);
  assign flim[2] = abz_lim(z_flt_sel);
  assign flim[3] = ctl_lim(ctl_flt_sel);
  assign flim[4] = ctl_lim(ctl_flt_sel);

  // Output follows input once it held for the selected time
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 5; i++) begin
      if (rst) begin
        fcnt_r[i] <= '0;
        // Primed to the pin level: an idle-high pin gives no edge after reset
        flt_r[i] <= sy2_r[i];
      end else if (sy2_r[i] == flt_r[i]) begin
        fcnt_r[i] <= '0;
      end else if (fcnt_r[i] >= flim[i]) begin
        fcnt_r[i] <= '0;
        flt_r[i] <= sy2_r[i];
      end else begin
        fcnt_r[i] <= fcnt_r[i] + 1'b1;
      end
    end
  end

  // Previous levels track through reset, so no false edge follows it
  always_ff @(posedge sys_clk) begin
    fltd_r <= flt_r;
    cmpd_r <= cmp_match;
  end

  assign {c1, c0, z, b, a} = flt_r;
  assign arise = a & ~fltd_r[0];
  assign aedge = a ^ fltd_r[0];
  assign brise = b & ~fltd_r[1];
  assign bedge = b ^ fltd_r[1];
  assign zrise = z & ~fltd_r[2];
  assign zfall = ~z & fltd_r[2];
  assign c0rise = c0 & ~fltd_r[3];
  assign c0fall = ~c0 & fltd_r[3];
  assign c1rise = c1 & ~fltd_r[4];
  assign c1fall = ~c1 & fltd_r[4];

  // Internal clock tick
  always_comb begin
    case (src_sel)
      SRC_I0: tick_lim = TICK_W'(ICLK0_NS * US_CYCLES / NS_PER_US - 1);
      SRC_I1: tick_lim = TICK_W'(ICLK1_NS * US_CYCLES / NS_PER_US - 1);
      SRC_I2: tick_lim = TICK_W'(ICLK2_NS * US_CYCLES / NS_PER_US - 1);
      SRC_I3: tick_lim = TICK_W'(ICLK3_NS * US_CYCLES / NS_PER_US - 1);
      default: tick_lim = '0;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst || src_sel == SRC_EXT || tick_r >= tick_lim) begin
      tick_r <= '0;
    end else begin
      tick_r <= tick_r + 1'b1;
    end
  end

  assign tick = (src_sel != SRC_EXT) && (tick_r >= tick_lim);

  // Count method decode
  always_comb begin
    raw_up = 1'b0;
    raw_dn = 1'b0;
    if (src_sel != SRC_EXT) begin
      raw_up = tick;
    end else begin
      case (method_sel)
        MTH_QX1: begin
          raw_up = arise & ~b;
          raw_dn = arise & b;
        end
        MTH_QX2: begin
          raw_up = aedge & (a != b);
          raw_dn = aedge & (a == b);
        end
        MTH_QX4: begin
          raw_up = (aedge & (a != b)) | (bedge & (a == b));
          raw_dn = (aedge & (a == b)) | (bedge & (a != b));
        end
        MTH_IX1: begin
          raw_up = arise;
          raw_dn = brise;
        end
        MTH_IX2: begin
          raw_up = aedge;
          raw_dn = bedge;
        end
        MTH_DX1: begin
          raw_up = arise & ~b;
          raw_dn = arise & b;
        end
        MTH_DX2: begin
          raw_up = aedge & ~b;
          raw_dn = aedge & b;
        end
        default: begin
          raw_up = 1'b0;
          raw_dn = 1'b0;
        end
      endcase
    end
  end

  // Gating by control inputs
  always_comb begin
    gate = 1'b1;
    case (ctl0_func)
      C0_EN_POS, C0_POS_CLR, C0_POS_PRE: gate = c0;
      C0_EN_NEG, C0_NEG_CLR, C0_NEG_PRE: gate = ~c0;
      default: gate = 1'b1;
    endcase
    case (ctl1_func)
      C1_EN_POS: gate = gate & c1;
      C1_EN_NEG: gate = gate & ~c1;
      default: gate = gate;
    endcase
  end

  // Simultaneous up and down cancel
  assign step_up = gate & ((reverse_dir ? raw_dn : raw_up) & ~(raw_up & raw_dn));
  assign step_dn = gate & ((reverse_dir ? raw_up : raw_dn) & ~(raw_up & raw_dn));

  assign cmp_clr = |((cmp_rst_rise & cmp_match & ~cmpd_r)
                   | (cmp_rst_fall & ~cmp_match & cmpd_r));

  always_comb begin
    do_clr = cmp_clr;
    do_pre = 1'b0;
    case (z_func)
      ZF_CLR_RISE: do_clr = do_clr | zrise;
      ZF_CLR_FALL: do_clr = do_clr | zfall;
      ZF_CLR_HIGH: do_clr = do_clr | z;
      ZF_CLR_LOW: do_clr = do_clr | ~z;
      ZF_PRE_RISE: do_pre = zrise;
      ZF_PRE_FALL: do_pre = zfall;
      ZF_PRE_HIGH: do_pre = z;
      ZF_PRE_LOW: do_pre = ~z;
      default: do_pre = 1'b0;
    endcase
    case (ctl0_func)
      C0_POS_CLR: do_clr = do_clr | c0rise;
      C0_NEG_CLR: do_clr = do_clr | c0fall;
      C0_POS_PRE: do_pre = do_pre | c0rise;
      C0_NEG_PRE: do_pre = do_pre | c0fall;
      default: do_pre = do_pre;
    endcase
  end

  assign at_upper = count_r >= upper_lim;
  assign at_lower = count_r <= lower_lim;
  assign ovf_ev = ~do_clr & ~do_pre & step_up & at_upper;
  assign unf_ev = ~do_clr & ~do_pre & step_dn & at_lower;

  // Clear beats preset beats counting
  always_comb begin
    count_nxt = count_r;
    if (do_clr) begin
      count_nxt = CNT_ZERO;
    end else if (do_pre) begin
      count_nxt = preset_val;
    end else if (step_up) begin
      if (!at_upper) begin
        count_nxt = CNT_W'(count_r + CNT_ONE);
      end else if (ring_mode) begin
        count_nxt = lower_lim;
      end
    end else if (step_dn) begin
      if (!at_lower) begin
        count_nxt = CNT_W'(count_r - CNT_ONE);
      end else if (ring_mode) begin
        count_nxt = upper_lim;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= default_val;
    end else begin
      count_r <= count_nxt;
    end
  end

  // Sticky flags, a new event wins over the clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ovf_r <= 1'b0;
      unf_r <= 1'b0;
    end else begin
      ovf_r <= (ovf_en & ovf_ev) | (ovf_r & ~flag_clr);
      unf_r <= (ovf_en & unf_ev) | (unf_r & ~flag_clr);
    end
  end

  function automatic logic cap_hit(input logic [2:0] sel, input logic b0, input logic b1,
                                   input logic r0, input logic f0, input logic r1,
                                   input logic f1);
    case (sel)
      CAP_C0_RISE: return r0 & ~b0;
      CAP_C0_FALL: return f0 & ~b0;
      CAP_C1_RISE: return r1 & ~b1;
      CAP_C1_FALL: return f1 & ~b1;
      default: return 1'b0;
    endcase
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cap0_trig_r <= 1'b0;
      cap1_trig_r <= 1'b0;
    end else begin
      cap0_trig_r <= cap_hit(cap0_sel, ctl0_func != C0_NONE, ctl1_func != C1_NONE,
                             c0rise, c0fall, c1rise, c1fall);
      cap1_trig_r <= cap_hit(cap1_sel, ctl0_func != C0_NONE, ctl1_func != C1_NONE,
                             c0rise, c0fall, c1rise, c1fall);
    end
  end

  assign cap_conflict = (ctl0_func != C0_NONE
                         && (cap0_sel == CAP_C0_RISE || cap0_sel == CAP_C0_FALL
                             || cap1_sel == CAP_C0_RISE || cap1_sel == CAP_C0_FALL))
                     || (ctl1_func != C1_NONE
                         && (cap0_sel == CAP_C1_RISE || cap0_sel == CAP_C1_FALL
                             || cap1_sel == CAP_C1_RISE || cap1_sel == CAP_C1_FALL));

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_RESET_DEFAULT: assert property (@(posedge sys_clk) disable iff (1'b0)
                                      rst |=> count_r == $past(default_val))
    else $error("count not loaded with default value");
  AST_RING_WRAP: assert property (ring_mode && step_up && at_upper && !do_clr && !do_pre
                                  |=> count_r == $past(lower_lim))
    else $error("ring counter did not wrap to lower limit");
  AST_LINEAR_HOLD: assert property (!ring_mode && step_up && at_upper && !do_clr && !do_pre
                                    |=> $stable(count_r))
    else $error("linear counter moved past upper limit");
  AST_OVF_SET: assert property (ovf_en && ovf_ev |=> ovf_r)
    else $error("overflow not reported");
  AST_OVF_CAUSE: assert property ($rose(ovf_r) |-> $past(ovf_en) && $past(ovf_ev))
    else $error("overflow flag set without cause");
  AST_Z_CLEAR: assert property (z_func == ZF_CLR_HIGH && z |=> count_r == CNT_ZERO)
    else $error("Z high level did not clear count");
  AST_Z_PRESET: assert property (z_func == ZF_PRE_RISE && zrise && !do_clr
                                 |=> count_r == $past(preset_val))
    else $error("Z rise did not load preset");
  AST_GATE_HOLD: assert property (!gate && !do_clr && !do_pre |=> $stable(count_r))
    else $error("count changed while gated off");
  AST_CMP_CLEAR: assert property (cmp_clr |=> count_r == CNT_ZERO)
    else $error("match flag edge did not clear count");
  AST_CAP_BLOCK: assert property (cap0_trig_r && $past(cap0_sel) == CAP_C0_RISE
                                  |-> $past(ctl0_func) == C0_NONE)
    else $error("gating control used as capture trigger");
  AST_REV_DIR: assert property (reverse_dir && raw_up && !raw_dn && gate |-> step_dn)
    else $error("reverse direction not applied");

  COV_RING_WRAP: cover property (ring_mode && step_up && at_upper && !do_clr && !do_pre);
  COV_QX4_DOWN: cover property (method_sel == MTH_QX4 && step_dn);
  COV_CMP_CLEAR: cover property (cmp_clr);
  COV_INT_TICK: cover property (src_sel == SRC_I0 && tick ##1 tick);
endmodule

// ===== hsc_pkg.sv
package hsc_pkg;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_US = 1000;
  localparam int FLT_W = 24;
  localparam int TICK_W = 24;
  localparam int CNT_W = 32;
  localparam int CMP_N = 16;
  // A/B/Z filter time constants, ns
  localparam int ABZ_T1_NS = 100;
  localparam int ABZ_T2_NS = 200;
  localparam int ABZ_T3_NS = 500;
  localparam int ABZ_T4_NS = 1000;
  localparam int ABZ_T5_NS = 2000;
  localparam int ABZ_T6_NS = 10000;
  // Control filter time constants, us
  localparam int CTL_T1_US = 2;
  localparam int CTL_T2_US = 5;
  localparam int CTL_T3_US = 10;
  localparam int CTL_T4_US = 20;
  localparam int CTL_T5_US = 50;
  localparam int CTL_T6_US = 100;
  localparam int CTL_T7_US = 500;
  localparam int CTL_T8_US = 1000;
  localparam int CTL_T9_US = 2000;
  localparam int CTL_T10_US = 5000;
  localparam int CTL_T11_US = 10000;
  localparam logic [3:0] CTL_FLT_DEFAULT = 4'h9;
  // Internal clock periods, ns
  localparam int ICLK0_NS = 250;
  localparam int ICLK1_NS = 1000;
  localparam int ICLK2_NS = 10000;
  localparam int ICLK3_NS = 100000;
  // Count source
  localparam logic [2:0] SRC_EXT = 3'h0;
  localparam logic [2:0] SRC_I0 = 3'h1;
  localparam logic [2:0] SRC_I1 = 3'h2;
  localparam logic [2:0] SRC_I2 = 3'h3;
  localparam logic [2:0] SRC_I3 = 3'h4;
  // Count method
  localparam logic [2:0] MTH_QX1 = 3'h0;
  localparam logic [2:0] MTH_QX2 = 3'h1;
  localparam logic [2:0] MTH_QX4 = 3'h2;
  localparam logic [2:0] MTH_IX1 = 3'h3;
  localparam logic [2:0] MTH_IX2 = 3'h4;
  localparam logic [2:0] MTH_DX1 = 3'h5;
  localparam logic [2:0] MTH_DX2 = 3'h6;
  // Z function
  localparam logic [3:0] ZF_NONE = 4'h0;
  localparam logic [3:0] ZF_CLR_RISE = 4'h1;
  localparam logic [3:0] ZF_CLR_FALL = 4'h2;
  localparam logic [3:0] ZF_CLR_HIGH = 4'h3;
  localparam logic [3:0] ZF_CLR_LOW = 4'h4;
  localparam logic [3:0] ZF_PRE_RISE = 4'h5;
  localparam logic [3:0] ZF_PRE_FALL = 4'h6;
  localparam logic [3:0] ZF_PRE_HIGH = 4'h7;
  localparam logic [3:0] ZF_PRE_LOW = 4'h8;
  // Control 0 function
  localparam logic [2:0] C0_NONE = 3'h0;
  localparam logic [2:0] C0_EN_POS = 3'h1;
  localparam logic [2:0] C0_EN_NEG = 3'h2;
  localparam logic [2:0] C0_POS_CLR = 3'h3;
  localparam logic [2:0] C0_NEG_CLR = 3'h4;
  localparam logic [2:0] C0_POS_PRE = 3'h5;
  localparam logic [2:0] C0_NEG_PRE = 3'h6;
  // Control 1 function
  localparam logic [1:0] C1_NONE = 2'h0;
  localparam logic [1:0] C1_EN_POS = 2'h1;
  localparam logic [1:0] C1_EN_NEG = 2'h2;
  // Capture trigger select
  localparam logic [2:0] CAP_NONE = 3'h0;
  localparam logic [2:0] CAP_C0_RISE = 3'h1;
  localparam logic [2:0] CAP_C0_FALL = 3'h2;
  localparam logic [2:0] CAP_C1_RISE = 3'h3;
  localparam logic [2:0] CAP_C1_FALL = 3'h4;
  localparam logic signed [CNT_W-1:0] CNT_ZERO = 32'sh0;
  localparam logic signed [CNT_W-1:0] CNT_ONE = 32'sh1;
endpackage

// ===== enc_model.sv
`timescale 1ns/10ps
module enc_model (
  // Clock
  input wire logic sys_clk,
  // Quadrature step requests
  input wire logic fwd,
  input wire logic bwd,
  // Direct pin drive
  input wire logic raw_en,
  input wire logic raw_a,
  input wire logic raw_b,
  // Encoder pins
  output logic a_out,
  output logic b_out
);
  logic [1:0] phase_r = 2'h0;
  always @(posedge sys_clk) begin
    if (fwd) begin
      phase_r <= phase_r + 2'h1;
    end else if (bwd) begin
      phase_r <= phase_r - 2'h1;
    end
  end
  // Gray order, A leads B when moving forward
  assign a_out = raw_en ? raw_a : (phase_r == 2'h1 || phase_r == 2'h2);
  assign b_out = raw_en ? raw_b : phase_r[1];
endmodule

// ===== tb.sv
`timescale 1ns/10ps
module tb;
  import hsc_pkg::*;
  localparam int USC = 4;
  localparam logic signed [CNT_W-1:0] DV = 32'sh9;
  localparam logic signed [CNT_W-1:0] PV = 32'sh4d;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic z_in = 1'b0;
  logic ctl0_in = 1'b0;
  logic ctl1_in = 1'b0;
  logic ring_mode = 1'b0;
  logic ovf_en = 1'b0;
  logic reverse_dir = 1'b0;
  logic flag_clr = 1'b0;
  logic [2:0] src_sel = SRC_EXT;
  logic [2:0] method_sel = MTH_QX1;
  logic [3:0] z_func = ZF_NONE;
  logic [2:0] ctl0_func = C0_NONE;
  logic [1:0] ctl1_func = C1_NONE;
  logic [2:0] ab_flt_sel = 3'h0;
  logic [2:0] z_flt_sel = 3'h0;
  logic [3:0] ctl_flt_sel = 4'h0;
  logic signed [CNT_W-1:0] upper_lim = 32'sh7fffffff;
  logic signed [CNT_W-1:0] lower_lim = 32'sh80000000;
  logic signed [CNT_W-1:0] default_val = 32'sh5;
  logic signed [CNT_W-1:0] preset_val = PV;
  logic [2:0] cap0_sel = CAP_NONE;
  logic [2:0] cap1_sel = CAP_NONE;
  logic [CMP_N-1:0] cmp_match = 16'h0;
  logic [CMP_N-1:0] cmp_rst_rise = 16'h0;
  logic [CMP_N-1:0] cmp_rst_fall = 16'h0;
  logic fwd = 1'b0;
  logic bwd = 1'b0;
  logic raw_en = 1'b0;
  logic raw_a = 1'b0;
  logic raw_b = 1'b0;
  logic a_in;
  logic b_in;
  logic signed [CNT_W-1:0] count_r;
  logic signed [CNT_W-1:0] c0;
  logic ovf_r;
  logic unf_r;
  logic cap0_trig_r;
  logic cap1_trig_r;
  logic cap_conflict;
  int miscompares = 0;
  int n_checks = 0;
  int n_cap0 = 0;
  int n_cap1 = 0;
  int ev;
  int st;
  int per [4] = '{1, 4, 40, 400};
  enc_model u_enc (.sys_clk, .fwd, .bwd, .raw_en, .raw_a, .raw_b, .a_out(a_in), .b_out(b_in));
  high_speed_counter_core #(.US_CYCLES(USC)) u_dut (
    .sys_clk, .rst, .a_in, .b_in, .z_in, .ctl0_in, .ctl1_in, .ring_mode, .ovf_en,
    .reverse_dir, .src_sel, .method_sel, .z_func, .ctl0_func, .ctl1_func, .ab_flt_sel,
    .z_flt_sel, .ctl_flt_sel, .upper_lim, .lower_lim, .default_val, .preset_val,
    .cap0_sel, .cap1_sel, .cmp_match, .cmp_rst_rise, .cmp_rst_fall, .flag_clr,
    .count_r, .ovf_r, .unf_r, .cap0_trig_r, .cap1_trig_r, .cap_conflict);
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    if (cap0_trig_r === 1'b1) n_cap0++;
    if (cap1_trig_r === 1'b1) n_cap1++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk_cnt(input logic signed [CNT_W-1:0] exp);
    n_checks++;
    if (count_r !== exp) begin
      miscompares++;
      $display("BAD %0t count %0d exp %0d", $time, count_r, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %0t flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic restart(input logic signed [CNT_W-1:0] dv);
    default_val = dv;
    rst = 1'b1;
    cyc(4);
    rst = 1'b0;
    cyc(4);
  endtask
  task automatic step(input logic d, input int n);
    repeat (n) begin
      fwd = d;
      bwd = !d;
      cyc(1);
      fwd = 1'b0;
      bwd = 1'b0;
      cyc(3);
    end
    cyc(4);
  endtask
  task automatic tgl(input int sel);
    case (sel)
      0: raw_a = !raw_a;
      1: raw_b = !raw_b;
      2: z_in = !z_in;
      3: ctl0_in = !ctl0_in;
      default: ctl1_in = !ctl1_in;
    endcase
  endtask
  // Pin away from idle for w cycles, back for w+4
  task automatic pulse(input int sel, input int n, input int w);
    repeat (n) begin
      tgl(sel);
      cyc(w);
      tgl(sel);
      cyc(w + 4);
    end
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end
  initial begin
    cyc(16);
    rst = 1'b0;
    cyc(4);
    chk_cnt(32'sh5);
    chk_bit(ovf_r, 1'b0);
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      for (int r = 0; r < 2; r++) begin
        method_sel = 3'(m);
        reverse_dir = r[0];
        restart(32'sh0);
        step(1'b1, 8);
        chk_cnt((r == 1 ? -2 : 2) * (1 << m));
        step(1'b0, 8);
        chk_cnt(32'sh0);
      end
    end
    reverse_dir = 1'b0;
    raw_en = 1'b1;
    for (int i = 0; i < 8; i++) begin
      method_sel = 3'(3 + i / 2);
      raw_b = (i >= 4) && i[0];
      restart(32'sh0);
      pulse((i < 4 && i[0]) ? 1 : 0, 3, 4);
      chk_cnt((i[0] ? -3 : 3) * ((i / 2) % 2 + 1));
    end
    $display("test methods done");
    method_sel = MTH_IX1;
    raw_b = 1'b0;
    upper_lim = 32'sh3;
    lower_lim = -32'sh2;
    ovf_en = 1'b1;
    restart(32'sh0);
    pulse(0, 2, 4);
    chk_cnt(32'sh2);
    chk_bit(ovf_r, 1'b0);
    pulse(0, 3, 4);
    chk_cnt(32'sh3);
    chk_bit(ovf_r, 1'b1);
    pulse(1, 1, 4);
    flag_clr = 1'b1;
    cyc(2);
    flag_clr = 1'b0;
    cyc(2);
    chk_bit(ovf_r, 1'b0);
    pulse(1, 5, 4);
    chk_cnt(-32'sh2);
    chk_bit(unf_r, 1'b1);
    ovf_en = 1'b0;
    ring_mode = 1'b1;
    restart(32'sh0);
    pulse(0, 4, 4);
    chk_cnt(-32'sh2);
    chk_bit(ovf_r, 1'b0);
    pulse(1, 1, 4);
    chk_cnt(32'sh3);
    ring_mode = 1'b0;
    upper_lim = 32'sh7fffffff;
    lower_lim = 32'sh80000000;
    $display("test limits done");
    for (int s = 0; s < 4; s++) begin
      src_sel = 3'(s + 1);
      restart(32'sh0);
      cyc(8);
      c0 = count_r;
      cyc(4 * per[s]);
      chk_cnt(c0 + 32'sh4);
    end
    src_sel = SRC_EXT;
    $display("test internal clock done");
    for (int f = 1; f < 9; f++) begin
      z_func = 4'(f);
      restart(DV);
      st = (f % 4 == 0) ? 0 : ((f % 4 == 2) ? 2 : 1);
      for (int k = 0; k < 3; k++) begin
        if (k > 0) tgl(2);
        cyc(6);
        chk_cnt(k >= st ? (f < 5 ? 0 : PV) : DV);
      end
    end
    z_func = ZF_NONE;
    $display("test z done");
    for (int k = 0; k < 8; k++) begin
      ctl0_func = (k < 6) ? 3'(k + 1) : C0_NONE;
      ctl1_func = (k < 6) ? C1_NONE : 2'(k - 5);
      ctl0_in = k[0];
      ctl1_in = k[0];
      restart(DV);
      pulse(0, 2, 4);
      chk_cnt(DV);
      ctl0_in = !k[0];
      ctl1_in = !k[0];
      cyc(6);
      ev = (k == 2 || k == 3) ? 0 : ((k == 4 || k == 5) ? PV : DV);
      chk_cnt(ev);
      pulse(0, 2, 4);
      chk_cnt(ev + 2);
    end
    ctl0_func = C0_NONE;
    ctl1_func = C1_NONE;
    ctl0_in = 1'b0;
    ctl1_in = 1'b0;
    $display("test controls done");
    cmp_rst_rise = 16'h0008;
    cmp_rst_fall = 16'h0020;
    restart(DV);
    cmp_match = 16'h0023;
    cyc(4);
    chk_cnt(DV);
    cmp_match = 16'h0003;
    cyc(4);
    chk_cnt(32'sh0);
    pulse(0, 1, 4);
    cmp_match = 16'h0000;
    cyc(4);
    chk_cnt(32'sh1);
    cmp_match = 16'h0008;
    cyc(4);
    chk_cnt(32'sh0);
    $display("test compare done");
    cap0_sel = CAP_C0_RISE;
    cap1_sel = CAP_C1_FALL;
    cyc(2);
    chk_bit(cap_conflict, 1'b0);
    n_cap0 = 0;
    n_cap1 = 0;
    pulse(3, 1, 4);
    pulse(4, 1, 4);
    chk_bit(n_cap0 == 1 && n_cap1 == 1, 1'b1);
    cap0_sel = CAP_C1_RISE;
    cap1_sel = CAP_C0_FALL;
    cyc(2);
    chk_bit(cap_conflict, 1'b0);
    n_cap0 = 0;
    n_cap1 = 0;
    pulse(3, 1, 4);
    pulse(4, 1, 4);
    chk_bit(n_cap0 == 1 && n_cap1 == 1, 1'b1);
    ctl0_func = C0_EN_POS;
    ctl1_func = C1_EN_NEG;
    cyc(2);
    chk_bit(cap_conflict, 1'b1);
    n_cap0 = 0;
    n_cap1 = 0;
    pulse(3, 1, 4);
    pulse(4, 1, 4);
    chk_bit(n_cap0 == 0 && n_cap1 == 0, 1'b1);
    cap0_sel = CAP_NONE;
    cap1_sel = CAP_NONE;
    ctl1_func = C1_NONE;
    $display("test capture done");
    ab_flt_sel = 3'h1;
    z_flt_sel = 3'h1;
    ctl_flt_sel = 4'h1;
    z_func = ZF_CLR_RISE;
    ctl0_func = C0_POS_CLR;
    ctl0_in = 1'b1;
    restart(32'sh0);
    cyc(20);
    pulse(0, 1, 3);
    chk_cnt(32'sh0);
    pulse(0, 1, 20);
    chk_cnt(32'sh1);
    pulse(3, 1, 3);
    chk_cnt(32'sh1);
    pulse(3, 1, 20);
    chk_cnt(32'sh0);
    pulse(0, 1, 20);
    pulse(2, 1, 3);
    chk_cnt(32'sh1);
    pulse(2, 1, 20);
    chk_cnt(32'sh0);
    $display("test filters done");
    end_of_test();
  end
endmodule
